/* logic/flash_flags_params.svh */
// Offsets, field positions and reset values of the flag and config bank.
// Assumes the serial-bus engine presents decoded byte accesses.
`ifndef FLASH_FLAGS_PARAMS_SVH
`define FLASH_FLAGS_PARAMS_SVH

// ============================================================
// Register offsets
`define OFS_EVENT_FLAGS      8'h00
`define OFS_PIN_INPUT_CFG    8'h01
`define OFS_FAULT_RESP_CFG   8'h02

// ============================================================
// Event flag bit positions
`define FLG_TIMEOUT          0
`define FLG_THERMAL          1
`define FLG_LED_FAULT        2
`define FLG_SYNC_ONE         3
`define FLG_SYNC_TWO         4
`define FLG_THERMISTOR       5
`define FLG_FLASH_SUPPLY     6
`define FLG_SUPPLY           7

// ============================================================
// Pin and input config bit positions
`define C1_STROBE_EN         2
`define C1_STROBE_POL        3
`define C1_THERM_MODE        4
`define C1_SYNC_ONE_POL      5
`define C1_SYNC_TWO_POL      6
`define C1_HW_LAMP           7
`define C1_WRITE_MASK        8'hfc

// ============================================================
// Fault response config bit positions
`define C2_SYNC_TWO_OFF      0
`define C2_THERM_OFF         1
`define C2_ADV_TIMING        2
`define C2_SUPPLY_OFF        3
`define C2_WRITE_MASK        8'h0f

// ============================================================
// Reset values
`define RST_EVENT_FLAGS      8'h00
`define RST_PIN_INPUT_CFG    8'h68
`define RST_FAULT_RESP_CFG   8'h00

`endif

/* logic/flash_flags_pkg.sv */
// Types shared by the flag and config bank.
// Assumes the params header is included by each user.
package flash_flags_pkg;

    typedef logic [7:0] byte_t;

    typedef struct packed {
        byte_t flags;
        byte_t cfg1;
        byte_t cfg2;
        byte_t rdata;
        logic  sync_one_act;
        logic  sync_two_act;
        logic  strobe_on;
        logic  torch_req;
        logic  off_req;
    } bank_state_t;

    typedef struct packed {
        logic [1:0] prev;
        logic [1:0] change;
    } watch_state_t;

endpackage

/* logic/sync_change_watch.sv */
// Flags any change of level on a group of synchronous input pins.
// Assumes the pins are already synchronous to clk.
`timescale 1ns/1ps

module sync_change_watch
    import flash_flags_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] change
);

    watch_state_t     st_reg;
    watch_state_t     st_next;
    logic [WIDTH-1:0] diff;

    // ============================================================
    // Per-pin change detect
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            assign diff[i] = level_in[i] ^ st_reg.prev[i];
        end
    endgenerate

    always_comb begin
        st_next        = st_reg;
        st_next.prev   = level_in;
        st_next.change = diff;
    end

    // Reset takes the stored level low, so a pin high at release reports once
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign change = st_reg.change;

endmodule // sync_change_watch

/* logic/flash_flags_bank.sv */
// Event flag, pin/input config and fault response registers.
// Assumes a serial-bus engine gives one-cycle read and write strobes
// with a byte offset, and analog monitors give synchronous levels.
`timescale 1ns/1ps
`include "flash_flags_params.svh"

// Notes on behaviour
// - Reading the flag register returns the flags, then clears all but those whose event is present in the read cycle.
// - Bit 0 sets on flash timeout; bit 1 on thermal shutdown.
// - Bit 2 sets on an open or shorted LED.
// - Bits 3 and 4 set when a sync input changes; bit 3 in sync role only.
// - Bit 5 sets when thermistor mode is on and the pin is below trip.
// - Bit 7 on supply monitor trip; bit 6 on flash supply trip.
// - Config one bit 7 picks hardware lamp role; a flash clears it.
// - Config one bits 6 and 5 set sync input polarities, high default.
// - Config one bit 2 enables strobe; bit 3 its active level.
// - Config one bit 4 makes the indicator pin a thermistor input.
// - Config two bit 0: second sync event gives torch or shutdown.
// - Config two bit 1: thermistor trip gives torch or shutdown.
// - Config two bit 3: supply trip gives torch or off; bit 2 timing.
module flash_flags_bank
    import flash_flags_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       flash_timeout,
    input  wire logic       thermal_trip,
    input  wire logic       led_fault,
    input  wire logic       thermistor_sense,
    input  wire logic       supply_mon_en,
    input  wire logic       supply_low,
    input  wire logic       flash_mon_en,
    input  wire logic       flash_turn_on,
    input  wire logic       flash_supply_low,
    input  wire logic       flash_done,
    input  wire logic       rf_sync_input_one,
    input  wire logic       rf_sync_input_two,
    input  wire logic       strobe_pin,
    output logic            sync_or_hw_lamp_pin,
    output logic            thermistor_mode,
    output logic            sync_one_active,
    output logic            sync_two_active,
    output logic            strobe_fire,
    output logic            advanced_timing_mode,
    output logic            lamp_to_torch,
    output logic            lamp_shutdown
);

    bank_state_t st_reg;
    bank_state_t st_next;
    logic [1:0]  sync_change;
    byte_t       events;
    logic        rd_flags;
    logic        therm_trip;
    logic        sup_trip;

    sync_change_watch #(
        .WIDTH    (2)
    ) u_watch (
        .clk      (clk),
        .rst      (rst),
        .level_in ({rf_sync_input_two, rf_sync_input_one}),
        .change   (sync_change)
    );

    // ============================================================
    // Event sources
    always_comb begin
        therm_trip = st_reg.cfg1[`C1_THERM_MODE] & thermistor_sense;
        sup_trip   = supply_mon_en & supply_low;
        events                    = '0;
        events[`FLG_TIMEOUT]      = flash_timeout;
        events[`FLG_THERMAL]      = thermal_trip;
        events[`FLG_LED_FAULT]    = led_fault;
        events[`FLG_SYNC_ONE]     = sync_change[0]
                                  & ~st_reg.cfg1[`C1_HW_LAMP];
        events[`FLG_SYNC_TWO]     = sync_change[1];
        events[`FLG_THERMISTOR]   = therm_trip;
        events[`FLG_FLASH_SUPPLY] = flash_mon_en & flash_turn_on
                                  & flash_supply_low;
        events[`FLG_SUPPLY]       = sup_trip;
    end

    // ============================================================
    // Register file and response logic
    always_comb begin
        st_next  = st_reg;
        rd_flags = reg_rd && (reg_addr == `OFS_EVENT_FLAGS);
        // Clear first, then OR events so a coinciding event is kept
        if (rd_flags) begin
            st_next.flags = '0;
        end
        st_next.flags = st_next.flags | events;
        if (reg_rd) begin
            case (reg_addr)
                `OFS_EVENT_FLAGS:    st_next.rdata = st_reg.flags;
                `OFS_PIN_INPUT_CFG:  st_next.rdata = st_reg.cfg1;
                `OFS_FAULT_RESP_CFG: st_next.rdata = st_reg.cfg2;
                default:             st_next.rdata = 8'h00;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                `OFS_PIN_INPUT_CFG: begin
                    st_next.cfg1 = reg_wdata & `C1_WRITE_MASK;
                end
                `OFS_FAULT_RESP_CFG: begin
                    st_next.cfg2 = reg_wdata & `C2_WRITE_MASK;
                end
                default: begin
                    st_next.cfg2 = st_next.cfg2;
                end
            endcase
        end
        // A flash ending beats a same-cycle write, so the pin falls back
        if (flash_done) begin
            st_next.cfg1[`C1_HW_LAMP] = 1'b0;
        end
        st_next.sync_one_act = (rf_sync_input_one
                             == st_reg.cfg1[`C1_SYNC_ONE_POL])
                             & ~st_reg.cfg1[`C1_HW_LAMP];
        st_next.sync_two_act = (rf_sync_input_two
                             == st_reg.cfg1[`C1_SYNC_TWO_POL]);
        st_next.strobe_on    = st_reg.cfg1[`C1_STROBE_EN]
                             & (strobe_pin
                             == st_reg.cfg1[`C1_STROBE_POL]);
        st_next.off_req   = (st_reg.sync_two_act
                              & st_reg.cfg2[`C2_SYNC_TWO_OFF])
                          | (therm_trip
                              & st_reg.cfg2[`C2_THERM_OFF])
                          | (sup_trip
                              & st_reg.cfg2[`C2_SUPPLY_OFF]);
        st_next.torch_req = (st_reg.sync_two_act
                              & ~st_reg.cfg2[`C2_SYNC_TWO_OFF])
                          | (therm_trip
                              & ~st_reg.cfg2[`C2_THERM_OFF])
                          | (sup_trip
                              & ~st_reg.cfg2[`C2_SUPPLY_OFF]);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg       <= '0;
            st_reg.flags <= `RST_EVENT_FLAGS;
            st_reg.cfg1  <= `RST_PIN_INPUT_CFG;
            st_reg.cfg2  <= `RST_FAULT_RESP_CFG;
        end else begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // Outputs
    assign reg_rdata            = st_reg.rdata;
    assign sync_or_hw_lamp_pin  = st_reg.cfg1[`C1_HW_LAMP];
    assign thermistor_mode      = st_reg.cfg1[`C1_THERM_MODE];
    assign sync_one_active      = st_reg.sync_one_act;
    assign sync_two_active      = st_reg.sync_two_act;
    assign strobe_fire          = st_reg.strobe_on;
    assign advanced_timing_mode = st_reg.cfg2[`C2_ADV_TIMING];
    assign lamp_to_torch        = st_reg.torch_req;
    assign lamp_shutdown        = st_reg.off_req;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_flag_read;
        reg_rd && reg_addr == `OFS_EVENT_FLAGS;
    endsequence

    sequence s_sync_one_change;
        $changed(rf_sync_input_one) && !st_reg.cfg1[`C1_HW_LAMP]
            ##1 !st_reg.cfg1[`C1_HW_LAMP];
    endsequence

    AST_READ_RETURNS: assert property (s_flag_read |=>
        reg_rdata == $past(st_reg.flags))
        else $error("flag read did not return flags");
    AST_READ_CLEARS: assert property ((s_flag_read and events == 8'h00)
        |=> st_reg.flags == 8'h00)
        else $error("flag read did not clear flags");
    AST_TIMEOUT_FLAG: assert property (flash_timeout |=>
        st_reg.flags[`FLG_TIMEOUT])
        else $error("timeout flag not set");
    AST_LED_FAULT_FLAG: assert property (led_fault |=>
        st_reg.flags[`FLG_LED_FAULT])
        else $error("led fault flag not set");
    AST_SYNC_ONE_FLAG: assert property (s_sync_one_change |=>
        st_reg.flags[`FLG_SYNC_ONE])
        else $error("sync one change not flagged");
    AST_THERM_FLAG: assert property ((thermistor_sense
        && thermistor_mode) |=> st_reg.flags[`FLG_THERMISTOR])
        else $error("thermistor flag not set");
    AST_SUPPLY_FLAG: assert property ((supply_mon_en && supply_low)
        |=> st_reg.flags[`FLG_SUPPLY])
        else $error("supply flag not set");
    AST_FLASH_CLEARS_LAMP: assert property (flash_done |=>
        !sync_or_hw_lamp_pin)
        else $error("hardware lamp role not cleared by flash");
    AST_STROBE_FIRE: assert property (strobe_fire ==
        $past(st_reg.cfg1[`C1_STROBE_EN]
        && strobe_pin == st_reg.cfg1[`C1_STROBE_POL]))
        else $error("strobe gating wrong");
    AST_SYNC_TWO_OFF: assert property ((sync_two_active
        && st_reg.cfg2[`C2_SYNC_TWO_OFF]) |=> lamp_shutdown)
        else $error("second sync did not shut lamp down");
    AST_EVENT_SURVIVES: assert property ((s_flag_read
        and thermal_trip) |=> st_reg.flags[`FLG_THERMAL])
        else $error("event lost in flag read");
    AST_THERMAL_FLAG: assert property (thermal_trip |=>
        st_reg.flags[`FLG_THERMAL])
        else $error("thermal flag not set");
    AST_FLASH_SUPPLY_FLAG: assert property ((flash_mon_en
        && flash_turn_on && flash_supply_low)
        |=> st_reg.flags[`FLG_FLASH_SUPPLY])
        else $error("flash supply flag not set");
    AST_SYNC_TWO_TORCH: assert property ((sync_two_active
        && !st_reg.cfg2[`C2_SYNC_TWO_OFF]) |=> lamp_to_torch)
        else $error("second sync did not force torch level");
    AST_CFG1_WRITE: assert property ((reg_wr
        && reg_addr == `OFS_PIN_INPUT_CFG && !flash_done)
        |=> st_reg.cfg1 == ($past(reg_wdata) & `C1_WRITE_MASK))
        else $error("config one write did not land");

endmodule // flash_flags_bank

/* dv/host_port_model.sv */
// Host side of the byte access port: one strobe per access.
// Assumes the bank answers a read on the edge after the strobe.
`timescale 1ns/1ps

module host_port_model
    import flash_flags_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic      [7:0] addr,
    output logic            wr,
    output logic            rd,
    output logic      [7:0] wdata
);
    initial begin
        addr  = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
        wdata = 8'h00;
    end

    // ============================================================
    // One access; address and data go to their inverse once released, strobes to zero
    task automatic access(input logic w, input byte_t a, input byte_t d,
                          output byte_t q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clk);
        addr  <= ~a;
        wdata <= ~d;
        wr    <= 1'b0;
        rd    <= 1'b0;
        @(negedge clk);
        q = rdata;
    endtask
endmodule // host_port_model

/* dv/tb.sv */
// Random and directed test of the flag and config bank.
// Assumes host_port_model issues the register accesses.
`timescale 1ns/1ps
`include "flash_flags_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
 $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb
    import flash_flags_pkg::*;
;
    logic  clk = 0, rst = 1, men = 0, s1 = 0, s2 = 0, stb = 0, done = 0;
    logic  fmen = 0, ton = 0;
    byte_t ev = 0, q, c, e, x;
    wire logic [7:0] addr, wdata, rdata;
    wire logic       wr, rd;
    logic  lamp, therm, act1, act2, fire, adv, torch, off;
    int    n_mismatch = 0, checks = 0;
    int    pos_t[3] = '{3, 1, 0}, ev_t[3] = '{7, 5, 4};
    logic [31:0] seed = 32'hbe8a;

    flash_flags_bank dut_u (
        .clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .flash_timeout(ev[0]),
        .thermal_trip(ev[1]), .led_fault(ev[2]), .thermistor_sense(ev[5]),
        .supply_mon_en(men), .supply_low(ev[7]), .flash_mon_en(fmen),
        .flash_turn_on(ton), .flash_supply_low(ev[6]), .flash_done(done),
        .rf_sync_input_one(ev[3] | s1), .rf_sync_input_two(ev[4] | s2),
        .strobe_pin(stb), .sync_or_hw_lamp_pin(lamp), .thermistor_mode(therm),
        .sync_one_active(act1), .sync_two_active(act2), .strobe_fire(fire),
        .advanced_timing_mode(adv), .lamp_to_torch(torch), .lamp_shutdown(off));

    host_port_model host_u (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
                            .rd(rd), .wdata(wdata));

    initial forever #4 clk = ~clk;

    // ============================================================
    // Helpers
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction

    // Gating of flags 3, 5, 6 and 7 by the config and monitor enables
    function automatic byte_t exp_flags(byte_t v, byte_t c1, logic m,
                                        logic fm, logic t);
        byte_t r;
        r = v;
        r[3] = v[3] & ~c1[7];
        r[5] = v[5] & c1[4];
        r[6] = v[6] & fm & t;
        r[7] = v[7] & m;
        return r;
    endfunction

    task automatic wr8(byte_t a, byte_t d);
        host_u.access(1'b1, a, d, q);
    endtask

    task automatic rd8(byte_t a);
        host_u.access(1'b0, a, 8'h00, q);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (10000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    // ============================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd8(`OFS_PIN_INPUT_CFG);
        `CHK("cfg1", 8'h68, q)
        rd8(`OFS_FAULT_RESP_CFG);
        `CHK("cfg2", 8'h00, q)
        wr8(`OFS_EVENT_FLAGS, 8'hff);
        rd8(`OFS_EVENT_FLAGS);
        `CHK("flags", 8'h00, q)
        rd8(8'h05);
        `CHK("unmapped", 8'h00, q)
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            c = seed[7:0] & 8'hfc;
            @(posedge clk);
            men <= seed[8];
            s1  <= seed[9];
            s2  <= seed[10];
            stb <= seed[11];
            fmen <= seed[12];
            ton  <= seed[13];
            // Raw byte, so the unused low bits are offered too
            wr8(`OFS_PIN_INPUT_CFG, seed[7:0]);
            repeat (3) @(posedge clk);
            `CHK("act1", s1 == c[5] && !c[7], act1)
            `CHK("act2", s2 == c[6], act2)
            `CHK("fire", c[2] && stb == c[3], fire)
            `CHK("therm", c[4], therm)
            `CHK("lamp", c[7], lamp)
            rd8(`OFS_PIN_INPUT_CFG);
            `CHK("cfg1", c, q)
            @(posedge clk);
            s1 <= 1'b0;
            s2 <= 1'b0;
            repeat (3) @(posedge clk);
            rd8(`OFS_EVENT_FLAGS);
            e = seed[31:24];
            @(posedge clk);
            ev <= e;
            @(posedge clk);
            ev <= 8'h00;
            repeat (3) @(posedge clk);
            rd8(`OFS_EVENT_FLAGS);
            x = exp_flags(e, c, men, fmen, ton);
            `CHK("flags", x, q)
            rd8(`OFS_EVENT_FLAGS);
            `CHK("flags", 8'h00, q)
        end
        // Event lands in the very cycle of the read strobe
        fork
            rd8(`OFS_EVENT_FLAGS);
            begin
                @(posedge clk);
                ev <= 8'h05;
                @(posedge clk);
                ev <= 8'h00;
            end
        join
        `CHK("flags", 8'h00, q)
        rd8(`OFS_EVENT_FLAGS);
        `CHK("flags", 8'h05, q)
        wr8(`OFS_PIN_INPUT_CFG, 8'h80);
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("lamp", 1'b0, lamp)
        rd8(`OFS_PIN_INPUT_CFG);
        `CHK("cfg1", 8'h00, q)
        wr8(`OFS_FAULT_RESP_CFG, 8'hff);
        rd8(`OFS_FAULT_RESP_CFG);
        `CHK("cfg2", 8'h0f, q)
        `CHK("adv", 1'b1, adv)
        wr8(`OFS_PIN_INPUT_CFG, 8'h78);
        @(posedge clk);
        men <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            for (int b = 0; b < 2; b++) begin
                wr8(`OFS_FAULT_RESP_CFG, 8'(b << pos_t[k]));
                @(posedge clk);
                ev <= 8'(1 << ev_t[k]);
                repeat (4) @(posedge clk);
                `CHK("off", b[0], off)
                `CHK("torch", !b[0], torch)
                ev <= 8'h00;
                repeat (3) @(posedge clk);
                rd8(`OFS_EVENT_FLAGS);
            end
        end
        wrap_up();
    end
endmodule // tb
